/* quad_out_defs.svh */
// Timing constants for the quadrature output block.
// Assumes a 25 MHz core clock; all counts derive from the times below.
`ifndef QUAD_OUT_DEFS_SVH
`define QUAD_OUT_DEFS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define QO_CLK_MHZ        25

// ----------------------------------------------------------------------
// Times in ns, as specified
// ----------------------------------------------------------------------
`define QO_RT_GAP_NS      1000
`define QO_BURST_GAP_NS   500
`define QO_ERR_WIDTH_NS   200
`define QO_RT_LAG_NS      1000
`define QO_RT_ONLY_LAG_NS 2500
`define QO_BURST_LAG_NS   5000
`define QO_BURST_REV_NS   10000

// ----------------------------------------------------------------------
// Cycle counts: least times round up, longest times round down
// ----------------------------------------------------------------------
`define QO_CEIL_CYC(ns)   (((ns) * `QO_CLK_MHZ + 999) / 1000)
`define QO_FLOOR_CYC(ns)  (((ns) * `QO_CLK_MHZ) / 1000)
`define QO_RT_GAP_CYC     `QO_CEIL_CYC(`QO_RT_GAP_NS)
`define QO_BURST_GAP_CYC  `QO_CEIL_CYC(`QO_BURST_GAP_NS)
`define QO_ERR_WIDTH_CYC  `QO_CEIL_CYC(`QO_ERR_WIDTH_NS)
`define QO_RT_LAG_CYC     `QO_FLOOR_CYC(`QO_RT_LAG_NS)
`define QO_RT_ONLY_LAG_CYC `QO_FLOOR_CYC(`QO_RT_ONLY_LAG_NS)
`define QO_BURST_LAG_CYC  `QO_FLOOR_CYC(`QO_BURST_LAG_NS)
`define QO_BURST_REV_CYC  `QO_FLOOR_CYC(`QO_BURST_REV_NS)

`endif

/* quad_out_pkg.sv */
// Types shared by the quadrature output block and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package quad_out_pkg;

  // --------------------------------------------------------------------
  // Output modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_REALTIME,
    MODE_BURST,
    MODE_ERROR,
    MODE_ALARM
  } out_mode_e;

  // --------------------------------------------------------------------
  // Differential line bundle
  // --------------------------------------------------------------------
  typedef struct packed {
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic z;
    logic z_n;
  } quad_lines_s;

endpackage : quad_out_pkg

/* quad_out.sv */
// Quadrature output generator: turns position steps from the sensing front
// end into differential phase A/B (and origin) lines, with mode selection.
// Assumes step, direction and status inputs come from logic on clk_i.
`timescale 1ns/10ps
`include "quad_out_defs.svh"

module quad_out #(
  parameter bit         BURST_EN       = 1'b1,
  parameter bit         HAS_ORIGIN     = 1'b1,
  parameter int         CNT_W          = 8,
  parameter logic [7:0] RT_GAP_CYC     = 8'(`QO_RT_GAP_CYC),
  parameter logic [7:0] BURST_GAP_CYC  = 8'(`QO_BURST_GAP_CYC),
  parameter logic [7:0] ERR_WIDTH_CYC  = 8'(`QO_ERR_WIDTH_CYC)
) (
  // Clock, reset, enable
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      ce_i,
  // Motion from the sensing front end
  input  wire logic                      step_i,
  input  wire logic                      step_retract_i,
  input  wire logic                      origin_i,
  // Speed and fault status
  input  wire logic                      over_rt_speed_i,
  input  wire logic                      over_response_i,
  input  wire logic                      disturb_i,
  input  wire logic                      alarm_i,
  // Differential output lines and current mode
  output quad_out_pkg::quad_lines_s      lines_o,
  output quad_out_pkg::out_mode_e        mode_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  quad_out_pkg::out_mode_e   mode,     next_mode;
  quad_out_pkg::quad_lines_s lines,    next_lines;
  logic signed [CNT_W-1:0]   pend,     next_pend;
  logic [1:0]                phase,    next_phase;
  logic [7:0]                gap,      next_gap;
  logic                      edge_now;

  localparam logic signed [CNT_W-1:0] PEND_MAX = {1'b0, {(CNT_W-1){1'b1}}};
  localparam logic signed [CNT_W-1:0] PEND_MIN = {1'b1, {(CNT_W-1){1'b0}}};
  // A signed one-bit literal would read as minus one, so spell out plus one
  localparam logic signed [CNT_W-1:0] PEND_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // Gray phase index to line levels; +1 gives A leading
  function automatic logic [1:0] phase_ab(input logic [1:0] p);
    phase_ab = {p[1] ^ p[0], p[1]};
  endfunction : phase_ab

  // ----------------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------------
  // Alarm outranks error, error outranks burst; no burst without the option
  always_comb begin
    if (alarm_i) begin
      next_mode = quad_out_pkg::MODE_ALARM;
    end else if (over_response_i || disturb_i) begin
      next_mode = quad_out_pkg::MODE_ERROR;
    end else if (BURST_EN && over_rt_speed_i) begin
      next_mode = quad_out_pkg::MODE_BURST;
    end else begin
      next_mode = quad_out_pkg::MODE_REALTIME;
    end
  end

  // ----------------------------------------------------------------------
  // Pending count, phase stepping and edge spacing
  // ----------------------------------------------------------------------
  // Pending holds steps not yet emitted; it is what the lag measures
  always_comb begin
    next_pend  = pend;
    next_phase = phase;
    next_gap   = (gap != 8'h00) ? gap - 8'h01 : 8'h00;
    next_lines = lines;
    edge_now   = 1'b0;
    case (mode)
      quad_out_pkg::MODE_REALTIME, quad_out_pkg::MODE_BURST: begin
        if (step_i) begin
          if (step_retract_i && pend != PEND_MAX) begin
            next_pend = pend + PEND_ONE;
          end else if (!step_retract_i && pend != PEND_MIN) begin
            next_pend = pend - PEND_ONE;
          end
        end
        // A real-time gap still running would stall burst output; cut it short.
        // The cut still leaves the burst least gap since the last edge.
        if (mode == quad_out_pkg::MODE_BURST && gap >= BURST_GAP_CYC) begin
          next_gap = (BURST_GAP_CYC > 8'h01) ? BURST_GAP_CYC - 8'h02 : 8'h00;
        end
        // One quarter step per edge, spaced by the mode's least gap
        if (pend != '0 && gap == 8'h00) begin
          edge_now = 1'b1;
          if (pend > 0) begin
            next_phase = phase + 2'h1;
            next_pend  = next_pend - PEND_ONE;
          end else begin
            next_phase = phase - 2'h1;
            next_pend  = next_pend + PEND_ONE;
          end
          next_gap = ((mode == quad_out_pkg::MODE_BURST) ? BURST_GAP_CYC
                                                         : RT_GAP_CYC) - 8'h01;
        end
        {next_lines.a, next_lines.b} = phase_ab(next_phase);
      end
      quad_out_pkg::MODE_ERROR: begin
        // Counts from an error spell are void, so drop them
        next_pend = '0;
        if (gap == 8'h00) begin
          edge_now     = 1'b1;
          next_lines.a = ~lines.a;
          next_lines.b = ~lines.a;
          next_gap     = ERR_WIDTH_CYC - 8'h01;
        end
        next_phase = {next_lines.b, next_lines.a ^ next_lines.b};
      end
      quad_out_pkg::MODE_ALARM: begin
        // Antiphase toggling never occurs in real-time or burst output
        next_pend = '0;
        if (gap == 8'h00) begin
          edge_now     = 1'b1;
          next_lines.a = ~lines.a;
          next_lines.b = lines.a;
          next_gap     = ERR_WIDTH_CYC - 8'h01;
        end
        next_phase = {next_lines.b, next_lines.a ^ next_lines.b};
      end
      default: begin
        next_pend = '0;
      end
    endcase
    next_lines.z   = HAS_ORIGIN ? origin_i : 1'b0;
    next_lines.a_n = ~next_lines.a;
    next_lines.b_n = ~next_lines.b;
    next_lines.z_n = ~next_lines.z;
  end

  // Registers; everything holds while the enable is low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode  <= quad_out_pkg::MODE_REALTIME;
      lines <= '{a: 1'b0, a_n: 1'b1, b: 1'b0, b_n: 1'b1, z: 1'b0, z_n: 1'b1};
      pend  <= '0;
      phase <= 2'h0;
      gap   <= 8'h00;
    end else if (ce_i) begin
      mode  <= next_mode;
      lines <= next_lines;
      pend  <= next_pend;
      phase <= next_phase;
      gap   <= next_gap;
    end
  end

  assign lines_o = lines;
  assign mode_o  = mode;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Cycles since the last A or B change, saturating
  logic [7:0] since_edge;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      since_edge <= 8'hff;
    end else if (ce_i) begin
      since_edge <= edge_now ? 8'h01 : ((since_edge == 8'hff) ? 8'hff : since_edge + 8'h01);
    end
  end

  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (!rst_b_i);

  a_diff_pairs: assert property (lines_o.a_n == ~lines_o.a
    && lines_o.b_n == ~lines_o.b && lines_o.z_n == ~lines_o.z)
    else $error("inverted line not complementary");
  a_quad_single: assert property ((mode_o inside {quad_out_pkg::MODE_REALTIME,
    quad_out_pkg::MODE_BURST}) && $past(mode_o) == mode_o
    |-> !($changed(lines_o.a) && $changed(lines_o.b)))
    else $error("both phases moved at once");
  a_retract_lead: assert property (edge_now && pend > 0
    && mode != quad_out_pkg::MODE_ERROR && mode != quad_out_pkg::MODE_ALARM
    |=> phase == $past(phase) + 2'h1)
    else $error("retract did not advance phase A");
  a_rt_gap: assert property (edge_now && mode == quad_out_pkg::MODE_REALTIME
    && since_edge != 8'hff |-> since_edge >= RT_GAP_CYC)
    else $error("real-time gap too short");
  a_burst_gap: assert property (edge_now && mode == quad_out_pkg::MODE_BURST
    && since_edge != 8'hff |-> since_edge >= BURST_GAP_CYC)
    else $error("burst gap too short");
  a_rt_lag: assert property (mode == quad_out_pkg::MODE_REALTIME && pend != '0
    && gap == 8'h00 |=> $changed(lines_o.a) || $changed(lines_o.b))
    else $error("pending step not emitted");
  a_burst_lag: assert property (mode == quad_out_pkg::MODE_BURST && pend != '0
    |-> ##[0:12] edge_now)
    else $error("burst output lagging");
  a_error_sync: assert property (mode == quad_out_pkg::MODE_ERROR && edge_now
    |=> lines_o.a == lines_o.b)
    else $error("error phases not in step");
  a_error_width: assert property (mode == quad_out_pkg::MODE_ERROR && edge_now
    && since_edge != 8'hff |-> since_edge >= ERR_WIDTH_CYC)
    else $error("error pulse too narrow");
  a_burst_enter: assert property (over_rt_speed_i && !over_response_i
    && !disturb_i && !alarm_i |=> mode_o == (BURST_EN ? quad_out_pkg::MODE_BURST
    : quad_out_pkg::MODE_REALTIME))
    else $error("wrong mode above real-time speed");
  a_alarm_mode: assert property (alarm_i |=> mode_o == quad_out_pkg::MODE_ALARM
    ##1 (mode_o != quad_out_pkg::MODE_ALARM || lines_o.a != lines_o.b
    || !$changed(lines_o.a)))
    else $error("alarm pattern missing");
  a_origin_follow: assert property (HAS_ORIGIN |=> lines_o.z == $past(origin_i))
    else $error("origin line not driven");

  c_burst_edge: cover property (mode_o == quad_out_pkg::MODE_BURST && edge_now);
  c_reversal:   cover property (edge_now && pend > 0 ##[1:40] edge_now && pend < 0);
  c_error_run:  cover property (mode_o == quad_out_pkg::MODE_ERROR && edge_now);
  c_alarm:      cover property (mode_o == quad_out_pkg::MODE_ALARM && edge_now);

endmodule : quad_out

/* quad_rx_model.sv */
// Host-side receiver model: quadrature counter with error-pattern detector.
// Assumes the gage lines are sampled on the generator clock.
`timescale 1ns/10ps
module quad_rx_model (
  // Clock and clear
  input  wire logic                      clk_i,
  input  wire logic                      clr_i,
  // Gage lines
  input  wire quad_out_pkg::quad_lines_s lines_i,
  // Count and error flag
  output logic signed [15:0]             count_o,
  output logic                           err_o
);
  logic [1:0] cur;
  logic [1:0] prev;
  logic [1:0] step;
  // A and B levels as a line receiver sees the pairs
  assign cur  = {lines_i.a & ~lines_i.a_n, lines_i.b & ~lines_i.b_n};
  assign step = {cur[0], cur[1] ^ cur[0]} - {prev[0], prev[1] ^ prev[0]};
  // Samples every clock, far above the 5 Mcps floor
  always @(posedge clk_i) begin
    prev <= cur;
    if (clr_i) begin
      count_o <= '0;
      err_o   <= 1'b0;
    end else if (step == 2'd2) begin
      err_o <= 1'b1; // Both phases moved at once: later counts invalid
    end else if (!err_o && step != 2'd0) begin
      count_o <= (step == 2'd1) ? count_o + 16'sd1 : count_o - 16'sd1;
    end
  end
endmodule : quad_rx_model

/* quad_out_tb.sv */
// Self-checking bench for the quadrature output generator.
// Assumes default gap parameters: 25, 13 and 5 cycles at 25 MHz.
`timescale 1ns/10ps
module quad_out_tb;
  logic clk_i, rst_b_i, ce_i, step_i, step_retract_i, origin_i, clr;
  logic over_rt_speed_i, over_response_i, disturb_i, alarm_i, err;
  quad_out_pkg::quad_lines_s lines_o;
  quad_out_pkg::out_mode_e   mode_o, lastm;
  logic signed [15:0]        count;
  logic [1:0]                expq[$];
  logic [1:0]                prev_ab;
  logic [1:0]                pat[4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int num_errors, comparisons, cyc, ph, net, gap, n, seed = 32'h0d9ce24a;
  int lim[4] = '{25, 13, 5, 0};

  quad_out DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .step_i(step_i),
    .step_retract_i(step_retract_i), .origin_i(origin_i),
    .over_rt_speed_i(over_rt_speed_i), .over_response_i(over_response_i),
    .disturb_i(disturb_i), .alarm_i(alarm_i), .lines_o(lines_o), .mode_o(mode_o));
  quad_rx_model rx (.clk_i(clk_i), .clr_i(clr), .lines_i(lines_o), .count_o(count),
    .err_o(err));

  // ----------------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------------
  task automatic chk_ab(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t phase lines %b, expected %b", $time, got, exp);
    end
  endtask : chk_ab
  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %0h, expected %0h", $time, got, exp);
    end
  endtask : chk_num
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------
  // Drivers, all on the falling edge
  // ----------------------------------------------------------------------
  task automatic step(input logic dir, input logic note);
    @(negedge clk_i) {step_i, step_retract_i} = {1'b1, dir};
    ph = (ph + (dir ? 1 : 3)) % 4;
    net += dir ? 1 : -1;
    if (note) expq.push_back(pat[ph]);
    @(negedge clk_i) step_i = 1'b0;
  endtask : step
  task automatic wait_q(input int lim_c);
    for (int i = 0; i < lim_c && expq.size() > 0; i++) @(negedge clk_i);
    chk_num(expq.size(), 0);
  endtask : wait_q
  task automatic count_ne(input int cycles);
    n = 0;
    repeat (cycles) @(negedge clk_i) n += (lines_o.a != lines_o.b);
  endtask : count_ne

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // Watcher: each real-time phase edge takes the oldest note; edges within one mode check spacing
  always @(negedge clk_i) if (rst_b_i) begin
    chk_num({lines_o.a ^ lines_o.a_n, lines_o.b ^ lines_o.b_n, lines_o.z ^ lines_o.z_n},
            3'b111);
    if ({lines_o.a, lines_o.b} !== prev_ab) begin
      if (mode_o == lastm) chk_num(gap >= lim[mode_o], 1);
      if (mode_o == quad_out_pkg::MODE_REALTIME && expq.size() > 0)
        chk_ab({lines_o.a, lines_o.b}, expq.pop_front());
      gap     = 0;
      lastm   = mode_o;
      prev_ab = {lines_o.a, lines_o.b};
    end
    gap++;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b_i, step_i, step_retract_i, origin_i, over_rt_speed_i} = '0;
    {over_response_i, disturb_i, alarm_i} = '0;
    {ce_i, clr} = 2'b11;
    gap     = 99;
    prev_ab = 2'b00;
    lastm   = quad_out_pkg::MODE_REALTIME;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    clr     = 1'b0;
    // Back-to-back steps both ways, then a lone step after idle
    repeat (4) step(1'b1, 1'b1);
    wait_q(110);
    repeat (4) step(1'b0, 1'b1);
    wait_q(110);
    repeat (30) @(negedge clk_i);
    step(1'b1, 1'b1);
    wait_q(25);
    // Burst: random directions at random spacing, net count must hold
    @(negedge clk_i) {clr, over_rt_speed_i, net} = {2'b11, 32'd0};
    @(negedge clk_i) clr = 1'b0;
    chk_num(mode_o, quad_out_pkg::MODE_BURST);
    repeat (40) begin
      step(1'($random(seed)), 1'b0);
      repeat (12 + ($random(seed) & 15)) @(negedge clk_i);
    end
    repeat (250) @(negedge clk_i);
    chk_num(32'(count), 32'(net));
    chk_num(err, 1'b0);
    // Origin mark follows its input one cycle later
    @(negedge clk_i) {over_rt_speed_i, origin_i} = 2'b01;
    @(negedge clk_i) chk_num({lines_o.z, mode_o}, {1'b1, quad_out_pkg::MODE_REALTIME});
    origin_i = 1'b0;
    // Over response speed: phases switch together
    over_response_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_num(mode_o, quad_out_pkg::MODE_ERROR);
    step(1'b1, 1'b0);
    count_ne(40);
    chk_num(n, 0);
    chk_num(err, 1'b1);
    // Alarm overrides a disturbance; once its first toggle is out, phases stay unequal
    @(negedge clk_i) {over_response_i, disturb_i, alarm_i} = 3'b011;
    repeat (8) @(negedge clk_i);
    chk_num(mode_o, quad_out_pkg::MODE_ALARM);
    count_ne(40);
    chk_num(n, 40);
    // Disturbance alone, once the alarm clears, is an error spell
    @(negedge clk_i) alarm_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_num(mode_o, quad_out_pkg::MODE_ERROR);
    end_sim();
  end
endmodule : quad_out_tb
